/* File: design/mic_defs.svh */
// constants for the interrupt controller: bit positions, resets, timing
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH
// core_irq_control bit positions
`define MIC_GIE_BIT   7
`define MIC_PERIPHERAL_IRQ_ENABLE_BIT  6
`define MIC_T0IE_BIT  5
`define MIC_INTE_BIT  4
`define MIC_GPIE_BIT  3
`define MIC_T0IF_BIT  2
`define MIC_INTF_BIT  1
`define MIC_GPIF_BIT  0
// peripheral flag / enable bit positions (same in both registers)
`define MIC_EE_BIT    7
`define MIC_AD_BIT    6
`define MIC_CM_BIT    3
`define MIC_T1_BIT    0
// implemented bits of the peripheral registers, others read zero
`define MIC_PER_MASK  8'hc9
// reset values
`define MIC_CTL_RST   8'h00
`define MIC_PFLG_RST  8'h00
`define MIC_PEN_RST   8'h00
// interrupt vector and program counter width
`define MIC_PC_W      13
`define MIC_VECTOR    13'h0004
// source count and event-to-vector latency in instruction cycles
`define MIC_NUM_SRC   7
`define MIC_LAT_MIN   3
`define MIC_LAT_MAX   4
`endif

/* File: design/mic_irq_ctrl.sv */
// interrupt collection, masking and dispatch for a small 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"

// Functional notes
// RULE_01: seven event sources are latched as flags
// RULE_02: global enable gates every request to core
// RULE_03: per-source enable blocks that source
// RULE_04: reset clears the global enable
// RULE_05: return_from_irq sets the global enable
// RULE_06: pin, port-change, timer_zero flags in control
// RULE_07: peripheral flags and enables in own registers
// RULE_08: accept clears enable, pushes, loads 0004h
// RULE_09: software polls and clears flags first
// RULE_10: pin/port event vectors in 3-4 cycles
// RULE_11: flags set regardless of any enable
// RULE_12: enable-clearing write blocks next-cycle take
// RULE_13: comparator request wakes device from sleep
// RULE_14: peripheral requests also need peripheral enable
// RULE_15: enabled request wakes; vectors only if enabled
// RULE_16: request is OR of gated pairs, no priority
// RULE_17: set from hardware beats software clear
module mic_irq_ctrl
    import mic_pkg::*;
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 clk_en_in,
    // one-cycle event pulses from the sources
    input  wire logic                 ext_pin_edge_in,
    input  wire logic                 timer_zero_ovf_in,
    input  wire logic                 port_change_in,
    input  wire logic                 cmp_change_in,
    input  wire logic                 adc_done_in,
    input  wire logic                 timer_one_ovf_in,
    input  wire logic                 eeprom_wr_done_in,
    // register writes from the core
    input  wire logic                 ctl_wr_in,
    input  wire logic [7:0]           ctl_wdata_in,
    input  wire logic                 pflag_wr_in,
    input  wire logic [7:0]           pflag_wdata_in,
    input  wire logic                 pen_wr_in,
    input  wire logic [7:0]           pen_wdata_in,
    // core status
    input  wire logic                 return_from_irq_in,
    input  wire logic                 late_phase_in,
    input  wire logic                 sleep_in,
    input  wire logic [`MIC_PC_W-1:0] pc_in,
    // register read-back
    output logic [7:0]                core_irq_control_out,
    output logic [7:0]                peripheral_irq_flags_out,
    output logic [7:0]                peripheral_irq_enables_out,
    // dispatch to the core
    output logic                      irq_req_out,
    output logic                      flush_out,
    output logic                      push_stack_out,
    output logic [`MIC_PC_W-1:0]      push_addr_out,
    output logic                      vector_load_out,
    output logic [`MIC_PC_W-1:0]      vector_addr_out,
    output logic                      wake_out
);

    // ==========================================================
    // register state
    // ==========================================================
    logic [7:0]           ctl;
    logic [7:0]           pflg;
    logic [7:0]           pen;
    logic [7:0]           next_ctl;
    logic [7:0]           next_pflg;
    logic [7:0]           next_pen;
    mic_state_t           state;
    mic_state_t           next_state;
    logic [`MIC_PC_W-1:0] ret_pc;
    logic [`MIC_PC_W-1:0] next_ret_pc;
    logic                 core_pend;
    logic                 per_pend;
    logic                 any_pend;
    logic                 gie_eff;
    logic                 accept;
    logic                 next_req;
    logic                 next_flush;
    logic                 next_push;
    logic                 next_vec;
    logic                 next_wake;

    // ==========================================================
    // request gating
    // ==========================================================
    // flag-and-enable pairs, ORed with no priority [RULE_16]
    assign core_pend =
        (ctl[`MIC_T0IF_BIT] & ctl[`MIC_T0IE_BIT]) |   // [RULE_03]
        (ctl[`MIC_INTF_BIT] & ctl[`MIC_INTE_BIT]) |
        (ctl[`MIC_GPIF_BIT] & ctl[`MIC_GPIE_BIT]);
    // peripheral pairs also pass the group enable [RULE_14]
    assign per_pend = ctl[`MIC_PERIPHERAL_IRQ_ENABLE_BIT]
                    & (|(pflg & pen & `MIC_PER_MASK)); // [RULE_03]
    assign any_pend = core_pend | per_pend;
    // a write clearing the enable blocks this cycle's take [RULE_12]
    assign gie_eff = ctl[`MIC_GIE_BIT]
                   & ~(ctl_wr_in & ~ctl_wdata_in[`MIC_GIE_BIT]);
    // sleeping core takes the vector only after waking
    assign accept = (state == MIC_IDLE) & gie_eff & any_pend
                  & ~sleep_in;                       // [RULE_02]

    // ==========================================================
    // register next values
    // ==========================================================
    // software write first, then events OR in so a set wins
    always_comb begin
        next_ctl  = ctl_wr_in ? ctl_wdata_in : ctl;
        next_pflg = pflg_sel(pflag_wr_in, pflag_wdata_in, pflg);
        next_pen  = pen_wr_in ? (pen_wdata_in & `MIC_PER_MASK) : pen;
        // events set flags whatever the enables [RULE_11] [RULE_01]
        next_ctl[`MIC_INTF_BIT] = next_ctl[`MIC_INTF_BIT]
                                | ext_pin_edge_in;   // [RULE_17] [RULE_06]
        next_ctl[`MIC_T0IF_BIT] = next_ctl[`MIC_T0IF_BIT]
                                | timer_zero_ovf_in; // [RULE_06]
        next_ctl[`MIC_GPIF_BIT] = next_ctl[`MIC_GPIF_BIT]
                                | port_change_in;    // [RULE_06]
        next_pflg[`MIC_EE_BIT]  = next_pflg[`MIC_EE_BIT]
                                | eeprom_wr_done_in; // [RULE_07]
        next_pflg[`MIC_AD_BIT]  = next_pflg[`MIC_AD_BIT] | adc_done_in;
        next_pflg[`MIC_CM_BIT]  = next_pflg[`MIC_CM_BIT] | cmp_change_in;
        next_pflg[`MIC_T1_BIT]  = next_pflg[`MIC_T1_BIT]
                                | timer_one_ovf_in;  // [RULE_17]
        // accepting drops the enable; return restores it
        if (accept) begin
            next_ctl[`MIC_GIE_BIT] = 1'b0;           // [RULE_08]
        end
        if (return_from_irq_in) begin
            next_ctl[`MIC_GIE_BIT] = 1'b1;           // [RULE_05]
        end
    end

    // keeps reserved peripheral flag bits at zero
    function automatic logic [7:0] pflg_sel(
        input logic       wr,
        input logic [7:0] wd,
        input logic [7:0] cur
    );
        pflg_sel = (wr ? wd : cur) & `MIC_PER_MASK;
    endfunction : pflg_sel

    // reset clears the global enable with the rest [RULE_04]
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctl  <= `MIC_CTL_RST;
            pflg <= `MIC_PFLG_RST;
            pen  <= `MIC_PEN_RST;
        end else if (clk_en_in) begin
            ctl  <= next_ctl;
            pflg <= next_pflg;
            pen  <= next_pen;
        end
    end

    // ==========================================================
    // dispatch sequence
    // ==========================================================
    // the hold step pads late events so latency does not
    // depend on the length of the interrupted instruction
    always_comb begin
        next_state  = state;
        next_ret_pc = ret_pc;
        next_flush  = 1'b0;
        next_push   = 1'b0;
        next_vec    = 1'b0;
        case (state)
            MIC_IDLE: begin
                if (accept) begin
                    next_state  = MIC_ARM;
                    next_ret_pc = pc_in;
                    next_flush  = 1'b1;
                end
            end
            MIC_ARM: begin
                next_flush = 1'b1;
                if (late_phase_in) begin
                    next_state = MIC_HOLD;           // [RULE_10]
                end else begin
                    next_state = MIC_VEC;
                    next_push  = 1'b1;
                    next_vec   = 1'b1;
                end
            end
            MIC_HOLD: begin
                next_state = MIC_VEC;
                next_flush = 1'b1;
                next_push  = 1'b1;                   // [RULE_08]
                next_vec   = 1'b1;                   // [RULE_10]
            end
            MIC_VEC: begin
                next_state = MIC_IDLE;
            end
            default: begin
                next_state = MIC_IDLE;
            end
        endcase
    end

    // ==========================================================
    // request and wake outputs
    // ==========================================================
    // wake needs an enabled request only, not the global enable
    always_comb begin
        next_req  = ctl[`MIC_GIE_BIT] & any_pend;    // [RULE_02]
        next_wake = sleep_in & any_pend;             // [RULE_15] [RULE_13]
    end

    // all outputs are registered copies
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state           <= MIC_IDLE;
            ret_pc          <= '0;
            irq_req_out     <= 1'b0;
            flush_out       <= 1'b0;
            push_stack_out  <= 1'b0;
            push_addr_out   <= '0;
            vector_load_out <= 1'b0;
            vector_addr_out <= `MIC_VECTOR;
            wake_out        <= 1'b0;
        end else if (clk_en_in) begin
            state           <= next_state;
            ret_pc          <= next_ret_pc;
            irq_req_out     <= next_req;
            flush_out       <= next_flush;
            push_stack_out  <= next_push;
            push_addr_out   <= next_ret_pc;
            vector_load_out <= next_vec;
            vector_addr_out <= `MIC_VECTOR;          // [RULE_08]
            wake_out        <= next_wake;
        end
    end

    assign core_irq_control_out       = ctl;
    assign peripheral_irq_flags_out   = pflg;
    assign peripheral_irq_enables_out = pen;

    // ==========================================================
    // checks
    // ==========================================================
    chk_reset_gie_clear: assert property ( // [RULE_04]
        @(posedge sys_clk_in) sys_rst_in |=> !ctl[`MIC_GIE_BIT])
        else $error("global enable not cleared by reset");

    chk_ret_sets_gie: assert property ( // [RULE_05]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && return_from_irq_in |=> ctl[`MIC_GIE_BIT])
        else $error("return did not set global enable");

    chk_flag_set_wins: assert property ( // [RULE_17]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && ext_pin_edge_in |=> ctl[`MIC_INTF_BIT])
        else $error("pin event lost");

    chk_t1_flag_set: assert property ( // [RULE_11]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && timer_one_ovf_in |=> pflg[`MIC_T1_BIT])
        else $error("timer_one flag not set");

    chk_no_req_gie_off: assert property ( // [RULE_02]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && !ctl[`MIC_GIE_BIT] |=> !irq_req_out)
        else $error("request with global enable off");

    chk_peripheral_irq_enable_gates: assert property ( // [RULE_14]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && !ctl[`MIC_PERIPHERAL_IRQ_ENABLE_BIT] && !core_pend
        |=> !irq_req_out)
        else $error("peripheral request without group enable");

    // frozen edges stretch a dispatch, so only unfrozen runs are timed
    // enable already dropped one edge after the take, vector follows
    chk_accept_vector: assert property ( // [RULE_08]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && accept && !return_from_irq_in ##1 clk_en_in[*2]
        |-> !$past(ctl[`MIC_GIE_BIT])
            ##[0:1] (vector_load_out && push_stack_out
                     && vector_addr_out == `MIC_VECTOR))
        else $error("accept without vector load");

    // counted in instruction cycles: two or three after the take
    chk_latency_pin: assert property ( // [RULE_10]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        state == MIC_IDLE && clk_en_in && accept
        && $past(ext_pin_edge_in) ##1 clk_en_in[*2]
        |-> ##[0:1] vector_load_out)
        else $error("pin latency out of range");

    chk_clear_blocks: assert property ( // [RULE_12]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && ctl_wr_in && !ctl_wdata_in[`MIC_GIE_BIT]
        |=> state == MIC_IDLE || $past(state) != MIC_IDLE)
        else $error("take during enable-clearing write");

    chk_wake_sleep: assert property ( // [RULE_15]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        clk_en_in && sleep_in && per_pend |=> wake_out)
        else $error("no wake for enabled request");

endmodule : mic_irq_ctrl
`default_nettype wire

/* File: design/mic_pkg.sv */
// types shared by the interrupt controller
`default_nettype none
package mic_pkg;
    // dispatch sequence, gray coded along idle-arm-hold-vector
    typedef enum logic [1:0] {
        MIC_IDLE = 2'b00,
        MIC_ARM  = 2'b01,
        MIC_HOLD = 2'b11,
        MIC_VEC  = 2'b10
    } mic_state_t;
endpackage : mic_pkg
`default_nettype wire

/* File: tb/mic_core_model.sv */
// behavioural processor core that serves the controller's interrupts
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"
// ==========================================================
// core model: follows the vector, clears flags, then returns
module mic_core_model (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 en_in,
    input  wire logic                 vec_in,
    input  wire logic                 slow_in,
    input  wire logic [7:0]           ctl_in,
    output logic                      rfi_out = 1'b0,
    output logic                      late_out = 1'b0,
    output logic                      clr_out = 1'b0,
    output logic [7:0]                ctl_wdata_out = 8'h00,
    output logic [`MIC_PC_W-1:0]      pc_out = 13'h0100
);
    logic       took;
    logic       held;
    logic [2:0] cnt;
    // remember whether the last edge was taken, so frozen edges hold
    always @(posedge clk_in) begin
        took <= en_in;
        held <= rst_in;
    end
    // drive just after each edge; slow mode spends longer in service
    always @(negedge clk_in) begin
        if (held) begin
            cnt     <= 3'h0;
            rfi_out <= 1'b0;
            clr_out <= 1'b0;
            pc_out  <= 13'h0100;
        end else if (took) begin
            pc_out        <= vec_in ? `MIC_VECTOR : pc_out + 13'h0001;
            late_out      <= 1'($urandom);
            cnt           <= vec_in ? (slow_in ? 3'h6 : 3'h2)
                                    : cnt - 3'(cnt != 3'h0);
            clr_out       <= cnt == 3'h2;
            ctl_wdata_out <= {1'b0, ctl_in[6:3], 3'b000};
            rfi_out       <= cnt == 3'h1;
        end
    end
endmodule : mic_core_model
`default_nettype wire

/* File: tb/tb_mic_irq_ctrl.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.svh"
// ==========================================================
// bench top: stimulus, reference model and comparisons
module tb_mic_irq_ctrl;
    logic        clk = 0, rst = 1, en = 1, slp = 0, slow = 0;
    logic [6:0]  ev = '0;
    logic        cwr = 0, pwr = 0, nwr = 0;
    logic [7:0]  cwd = '0, pwd = '0, nwd = '0;
    logic        rfi, late, clr, irq, fl, ps, vl, wk, m_irq, m_wk;
    logic [7:0]  p_cwd, ctl_o, pf_o, pe_o, m_ctl, m_pf, m_pe;
    logic [12:0] pc, pa, va, m_pa;
    logic        chk_on = 0;
    int          m_st, miscompares = 0, comparisons = 0, n;
    // core writes win the shared write ports while it services
    wire logic       e_cwr = cwr | clr;
    wire logic [7:0] e_cwd = clr ? p_cwd : cwd;
    wire logic       e_pwr = pwr | clr;
    wire logic [7:0] e_pwd = clr ? 8'h00 : pwd;

    always #5 clk = ~clk;

    mic_irq_ctrl dut (
        .sys_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
        .ext_pin_edge_in(ev[0]), .timer_zero_ovf_in(ev[1]),
        .port_change_in(ev[2]), .cmp_change_in(ev[3]),
        .adc_done_in(ev[4]), .timer_one_ovf_in(ev[5]),
        .eeprom_wr_done_in(ev[6]), .ctl_wr_in(e_cwr),
        .ctl_wdata_in(e_cwd), .pflag_wr_in(e_pwr),
        .pflag_wdata_in(e_pwd), .pen_wr_in(nwr), .pen_wdata_in(nwd),
        .return_from_irq_in(rfi), .late_phase_in(late),
        .sleep_in(slp), .pc_in(pc), .core_irq_control_out(ctl_o),
        .peripheral_irq_flags_out(pf_o),
        .peripheral_irq_enables_out(pe_o), .irq_req_out(irq),
        .flush_out(fl), .push_stack_out(ps), .push_addr_out(pa),
        .vector_load_out(vl), .vector_addr_out(va), .wake_out(wk));

    mic_core_model core (
        .clk_in(clk), .rst_in(rst), .en_in(en), .vec_in(vl),
        .slow_in(slow), .ctl_in(ctl_o), .rfi_out(rfi),
        .late_out(late), .clr_out(clr), .ctl_wdata_out(p_cwd),
        .pc_out(pc));

    // ======================================================
    // reference model, stepped on every edge with en high
    always @(posedge clk) begin : model
        logic [7:0] c;
        logic       any;
        logic       acc;
        c   = m_ctl;
        any = (c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0])
            | (c[6] & (|(m_pf & m_pe)));
        acc = m_st == 0 && c[7] && any && !slp && !(e_cwr && !e_cwd[7]);
        chk_on = 1'b1;
        if (rst) begin
            {m_ctl, m_pf, m_pe, m_irq, m_wk} = '0;
            m_st = 0;
        end else if (en) begin
            case (m_st)
                0: m_st = acc ? 1 : 0;
                1: m_st = late ? 2 : 3;
                2: m_st = 3;
                default: m_st = 0;
            endcase
            if (acc) m_pa = pc;
            m_irq = c[7] & any;
            m_wk  = slp & any;
            m_ctl = (e_cwr ? e_cwd : c) | {5'h00, ev[1], ev[0], ev[2]};
            if (acc) m_ctl[7] = 1'b0;
            if (rfi) m_ctl[7] = 1'b1;
            m_pf  = ((e_pwr ? e_pwd : m_pf)
                  | {ev[6], ev[4], 2'b00, ev[3], 2'b00, ev[5]})
                  & `MIC_PER_MASK;
            if (nwr) m_pe = nwd & `MIC_PER_MASK;
        end
    end

    // compare every settled output against the model
    always @(negedge clk) begin
        if (chk_on) begin
            check(16'(ctl_o), 16'(m_ctl));
            check(16'(pf_o), 16'(m_pf));
            check(16'(pe_o), 16'(m_pe));
            check(16'({irq, wk}), 16'({m_irq, m_wk}));
            check(16'({fl, vl, ps}), 16'({m_st != 0,
                m_st == 3, m_st == 3}));
            check(16'(va), 16'(`MIC_VECTOR));
            if (m_st == 3) check(16'(pa), 16'(m_pa));
        end
    end

    // ======================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // one write cycle: r selects control, flags or enables
    task automatic wr(input int r, input logic [7:0] d);
        @(negedge clk);
        {cwr, pwr, nwr} = 3'b100 >> r;
        {cwd, pwd, nwd} = {3{d}};
        @(negedge clk);
        {cwr, pwr, nwr} = 3'b000;
    endtask : wr

    task automatic pulse(input logic [6:0] e);
        @(negedge clk) ev = e;
        @(negedge clk) ev = 7'h00;
    endtask : pulse

    // bounded wait for the vector pulse (0) or the global enable (1)
    task automatic wait_for(input int what, output int k);
        k = 0;
        do begin
            @(negedge clk);
            ev = 7'h00;
            k++;
        end while ((what != 0 ? ctl_o[7] : vl) !== 1'b1 && k < 40);
        if ((what != 0 ? ctl_o[7] : vl) !== 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask : wait_for

    // ======================================================
    // main sequence
    initial begin
        void'($urandom(77078));
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int i = 0; i < `MIC_NUM_SRC; i++) pulse(7'(1 << i));
        wr(0, 8'h00);
        wr(1, 8'h00);
        $display("test flags done");
        wr(0, 8'h98);
        for (int i = 0; i < 4; i++) begin
            slow = i[1];
            @(negedge clk) ev = i[0] ? 7'h04 : 7'h01;
            wait_for(0, n);
            check(16'(n == 3 || n == 4), 16'h0001);
            wait_for(1, n);
        end
        $display("test latency done");
        wr(0, 8'h80);
        wr(2, 8'hff);
        pulse(7'h78);
        wr(0, 8'hc0);
        wait_for(0, n);
        wait_for(1, n);
        wr(0, 8'h90);
        @(negedge clk) ev = 7'h01;
        @(negedge clk) {ev, cwr, cwd} = {7'h00, 1'b1, 8'h12};
        @(negedge clk) cwr = 1'b0;
        repeat (4) @(negedge clk);
        wr(0, 8'h92);
        wait_for(0, n);
        wait_for(1, n);
        $display("test gating done");
        wr(0, 8'h40);
        wr(2, 8'h08);
        slp = 1'b1;
        pulse(7'h08);
        wr(0, 8'hc0);
        repeat (3) @(negedge clk);
        slp = 1'b0;
        wait_for(0, n);
        wait_for(1, n);
        {cwd, pwd} = 16'h4000;
        @(negedge clk) {cwr, pwr, ev} = {2'b11, 7'h11};
        @(negedge clk) {cwr, pwr, ev} = 9'h000;
        $display("test sleep done");
        wr(0, 8'hf8);
        wr(2, 8'hc9);
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            ev   = 7'($urandom & $urandom & $urandom);
            en   = ($urandom % 8) != 0;
            slp  = ($urandom % 16) == 0;
            slow = i[5];
        end
        @(negedge clk) {ev, en, slp, rst} = 10'b0000000_1_0_1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        $display("test random done");
        end_sim();
    end
endmodule : tb_mic_irq_ctrl
`default_nettype wire
